// ---- rtl/rftx_pkg.sv ----
/*
  Package for the RF transmit control block: register offsets, field positions,
  reset values, timing constants, state type and carrier structs.
  Assumes a 10 MHz system clock standing in for the crystal-derived clock.
*/
package rftx_pkg;

  // ****************************************
  // Register map (word index on the plain port)
  // ****************************************
  localparam logic [3:0] ADDR_BIT_RATE = 4'h0;
  localparam logic [3:0] ADDR_FRAME_LEN = 4'h1;
  localparam logic [3:0] ADDR_TX_CTRL = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_BUF_BASE = 4'h0;
  localparam int ADDR_W = 6;
  localparam logic [5:0] ADDR_BUF_WIN = 6'h20;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CTRL_SEND_BIT = 7;
  localparam int CTRL_PAGE_BIT = 6;
  localparam int CTRL_EOM_BIT = 5;
  localparam logic [7:0] BIT_RATE_RST = 8'h34;
  localparam logic [7:0] FRAME_LEN_RST = 8'h00;
  localparam logic [4:0] POWER_RST = 5'h00;
  localparam logic [1:0] EOM_BITS = 2'h2;

  // ****************************************
  // Timing: crystal 26 MHz divided by 52*(code+1)
  // ****************************************
  localparam int XTAL_HZ = 26000000;
  localparam int RATE_PRESCALE = 52;
  localparam int CLK_HZ = 10000000;
  localparam int PRESCALE_CYC = (RATE_PRESCALE * CLK_HZ + XTAL_HZ - 1) / XTAL_HZ;
  localparam int BUF_BYTES = 32;

  typedef enum logic [1:0] {
    RFTX_IDLE = 2'b00,
    RFTX_DATA = 2'b01,
    RFTX_TAIL = 2'b11
  } rftx_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rftx_bus_t;

  typedef struct packed {
    logic active;
    logic data;
    logic [4:0] power;
  } rftx_tx_t;

endpackage

// ---- rtl/rftx_rate_div.sv ----
/*
  Bit-rate divider: emits a one-cycle tick every 52*(code+1) crystal periods,
  scaled to the system clock. Assumes i_run low clears it between frames.
*/
module rftx_rate_div
  import rftx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic [7:0] i_code,
  output logic o_tick
);
  logic [7:0] pre_cnt;
  logic [7:0] code_cnt;
  wire pre_end = (pre_cnt == 8'(PRESCALE_CYC - 1));
  wire code_end = (code_cnt == i_code);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !i_run) begin
      pre_cnt <= 8'h00;
      code_cnt <= 8'h00;
      o_tick <= 1'b0;
    end else begin
      pre_cnt <= pre_end ? 8'h00 : pre_cnt + 8'h01;
      if (pre_end) begin
        code_cnt <= code_end ? 8'h00 : code_cnt + 8'h01;
      end
      o_tick <= pre_end && code_end;
    end
  end
endmodule

// ---- rtl/rftx_buffer.sv ----
/*
  RF data buffer of 32 bytes in flip-flops, written a byte at a time, read by
  byte index for software and by bit index for the shifter.
*/
module rftx_buffer
  import rftx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [4:0] i_raddr,
  input wire logic [7:0] i_bit_idx,
  output logic [7:0] o_rdata,
  output logic o_bit
);
  logic [7:0] mem [BUF_BYTES];

  genvar g;
  generate
    for (g = 0; g < BUF_BYTES; g++) begin : g_byte
      always_ff @(posedge i_mclk) begin
        if (i_we && i_waddr == 5'(g)) begin
          mem[g] <= i_wdata;
        end
      end
    end
  endgenerate

  assign o_rdata = mem[i_raddr];
  // Bits go out MSB first within each byte
  assign o_bit = mem[i_bit_idx[7:3]][3'h7 - i_bit_idx[2:0]];
endmodule

// ---- rtl/rftx_ctrl.sv ----
/*
  RF transmit control: bit rate, frame length, power, start/abort, buffer page
  and end-of-message tail, reached over a plain register port.
  Assumes a 10 MHz clock, processor reset i_rst_n and RF-module reset i_rfm_rst_n,
  both synchronous and active low.
*/
// Implementation choices: the register offsets and strobed register access.
module rftx_ctrl
  import rftx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_rfm_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_tx_active,
  output logic o_tx_data,
  output logic [4:0] o_power,
  output logic o_bank_upper
);
  import rftx_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] bit_rate;
  logic [7:0] frame_length;
  logic send;
  logic buffer_page_select;
  logic end_of_message_tail;
  logic [4:0] output_power_level;
  rftx_state_t state;
  rftx_state_t next_state;
  logic [7:0] bit_idx;
  logic [1:0] tail_cnt;
  logic tick;
  logic buf_bit;
  logic [7:0] buf_rdata;
  rftx_bus_t bus;
  rftx_tx_t tx;

  // ****************************************
  // Decode
  // ****************************************
  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  wire is_win = (bus.addr[5] == ADDR_BUF_WIN[5]);
  wire [3:0] reg_idx = bus.addr[3:0];
  wire wr_rate = bus.wr && !is_win && reg_idx == ADDR_BIT_RATE;
  wire wr_len = bus.wr && !is_win && reg_idx == ADDR_FRAME_LEN;
  wire wr_ctrl = bus.wr && !is_win && reg_idx == ADDR_TX_CTRL;
  wire wr_buf = bus.wr && is_win;
  wire [4:0] buf_addr = {buffer_page_select, bus.addr[3:0]};
  wire start_req = wr_ctrl && bus.wdata[CTRL_SEND_BIT] && state == RFTX_IDLE;
  wire abort_req = wr_ctrl && !bus.wdata[CTRL_SEND_BIT];
  wire last_bit = (bit_idx == frame_length);
  wire [7:0] ctrl_rd = {send, buffer_page_select, end_of_message_tail, output_power_level};
  wire [7:0] status_rd = {6'h00, state};
  wire [7:0] reg_rd = (reg_idx == ADDR_BIT_RATE) ? bit_rate :
                      (reg_idx == ADDR_FRAME_LEN) ? frame_length :
                      (reg_idx == ADDR_TX_CTRL) ? ctrl_rd :
                      (reg_idx == ADDR_STATUS) ? status_rd : 8'h00;
  wire [7:0] next_rdata = !bus.rd ? 8'h00 : is_win ? buf_rdata : reg_rd;

  // ****************************************
  // Submodules
  // ****************************************
  rftx_rate_div u_div (
    .i_mclk(i_mclk),
    .i_rst_n(i_rfm_rst_n),
    .i_run(state != RFTX_IDLE),
    .i_code(bit_rate),
    .o_tick(tick)
  );

  rftx_buffer u_buf (
    .i_mclk(i_mclk),
    .i_we(wr_buf),
    .i_waddr(buf_addr),
    .i_wdata(bus.wdata),
    .i_raddr(buf_addr),
    .i_bit_idx(bit_idx),
    .o_rdata(buf_rdata),
    .o_bit(buf_bit)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      RFTX_IDLE: begin
        if (start_req && frame_length != FRAME_LEN_RST) begin
          next_state = RFTX_DATA;
        end
      end
      RFTX_DATA: begin
        if (abort_req) begin
          next_state = RFTX_IDLE;
        end else if (tick && last_bit) begin
          next_state = end_of_message_tail ? RFTX_TAIL : RFTX_IDLE;
        end
      end
      RFTX_TAIL: begin
        if (abort_req || (tick && tail_cnt == EOM_BITS - 2'h1)) begin
          next_state = RFTX_IDLE;
        end
      end
      default: begin
        next_state = RFTX_IDLE;
      end
    endcase
  end

  assign tx.active = (next_state != RFTX_IDLE);
  assign tx.data = (next_state == RFTX_TAIL) ? 1'b1 : (next_state == RFTX_DATA) && buf_bit;
  assign tx.power = output_power_level;

  always_ff @(posedge i_mclk) begin
    if (!i_rfm_rst_n) begin
      state <= RFTX_IDLE;
      bit_idx <= 8'h00;
      tail_cnt <= 2'h0;
    end else begin
      state <= next_state;
      if (next_state == RFTX_IDLE || start_req) begin
        bit_idx <= 8'h00;
      end else if (state == RFTX_DATA && tick && !last_bit) begin
        bit_idx <= bit_idx + 8'h01;
      end
      tail_cnt <= (state == RFTX_TAIL) ? tail_cnt + {1'b0, tick} : 2'h0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rfm_rst_n) begin
      bit_rate <= BIT_RATE_RST;
      frame_length <= FRAME_LEN_RST;
      end_of_message_tail <= 1'b0;
      output_power_level <= POWER_RST;
    end else begin
      if (wr_rate) begin
        bit_rate <= bus.wdata;
      end
      if (wr_len) begin
        frame_length <= bus.wdata;
      end
      if (wr_ctrl) begin
        end_of_message_tail <= bus.wdata[CTRL_EOM_BIT];
        output_power_level <= bus.wdata[4:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rfm_rst_n) begin
      send <= 1'b0;
    end else begin
      send <= tx.active;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      buffer_page_select <= 1'b0;
      o_bank_upper <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        buffer_page_select <= bus.wdata[CTRL_PAGE_BIT];
      end
      o_bank_upper <= wr_ctrl ? bus.wdata[CTRL_PAGE_BIT] : buffer_page_select;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !i_rfm_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // Processor reset leaves the transmitter outputs running
  always_ff @(posedge i_mclk) begin
    if (!i_rfm_rst_n) begin
      o_tx_active <= 1'b0;
      o_tx_data <= 1'b0;
      o_power <= POWER_RST;
    end else begin
      o_tx_active <= tx.active;
      o_tx_data <= tx.data;
      o_power <= tx.power;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_rate_reset: assert property (@(posedge i_mclk) !i_rfm_rst_n |=> bit_rate == BIT_RATE_RST)
    else $error("bit rate not reset to default");
  a_len_reset: assert property (@(posedge i_mclk) !i_rfm_rst_n |=> frame_length == 8'h00)
    else $error("frame length not cleared");
  a_zero_len: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    (state == RFTX_IDLE && frame_length == 8'h00 && !wr_len) |=> state == RFTX_IDLE)
    else $error("frame sent with zero length");
  a_start_go: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n || !i_rst_n)
    (start_req && frame_length != 8'h00) |=> send && o_tx_active)
    else $error("start did not begin frame");
  a_abort_stop: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    (state != RFTX_IDLE && abort_req) |=> !send && state == RFTX_IDLE)
    else $error("abort ignored");
  a_send_busy: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    send == (state != RFTX_IDLE))
    else $error("send flag disagrees with state");
  a_bit_count: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    state == RFTX_DATA |-> bit_idx <= frame_length)
    else $error("bit index past frame length");
  a_tail_one: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n || !i_rst_n)
    state == RFTX_TAIL |=> o_tx_data || state == RFTX_IDLE)
    else $error("tail not data one");
  a_page_keep: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!i_rfm_rst_n && !wr_ctrl) |=> buffer_page_select == $past(buffer_page_select))
    else $error("page changed by module reset");
  a_power_pass: assert property (@(posedge i_mclk) disable iff (!i_rst_n || !i_rfm_rst_n)
    ##1 o_power == $past(output_power_level))
    else $error("power code altered");
  a_send_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n || !i_rfm_rst_n)
    (bus.rd && !is_win && reg_idx == ADDR_TX_CTRL) |=> o_rdata[CTRL_SEND_BIT] == $past(state != RFTX_IDLE))
    else $error("start bit read disagrees with activity");
  a_idle_quiet: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    next_state == RFTX_IDLE |=> !o_tx_active && !o_tx_data)
    else $error("output active while idle");
  a_abort_out: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    (state != RFTX_IDLE && abort_req) |=> !o_tx_active)
    else $error("carrier kept after abort");
  a_tail_count: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    state == RFTX_TAIL |-> tail_cnt < EOM_BITS)
    else $error("tail longer than two bits");
  a_no_tail: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    (state == RFTX_DATA && tick && last_bit && !end_of_message_tail && !abort_req) |=> state == RFTX_IDLE)
    else $error("tail added without tail bit");
  a_bank_page: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_bank_upper == buffer_page_select)
    else $error("bank select differs from page bit");
  a_page_reset: assert property (@(posedge i_mclk)
    !i_rst_n |=> !buffer_page_select)
    else $error("page bit not cleared by processor reset");
  a_eom_reset: assert property (@(posedge i_mclk)
    !i_rfm_rst_n |=> !end_of_message_tail)
    else $error("tail bit not cleared");
  a_power_clear: assert property (@(posedge i_mclk)
    !i_rfm_rst_n |=> output_power_level == POWER_RST)
    else $error("power field not cleared");
  a_step_one: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    (state == RFTX_DATA && !tick) |=> bit_idx == $past(bit_idx) || state == RFTX_IDLE)
    else $error("bit index moved without tick");
  a_tick_single: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    tick |=> !tick)
    else $error("divider tick longer than one cycle");
  a_len_write: assert property (@(posedge i_mclk) disable iff (!i_rfm_rst_n)
    wr_len |=> frame_length == $past(bus.wdata))
    else $error("frame length write lost");
  c_full_frame: cover property (@(posedge i_mclk) state == RFTX_DATA ##1 state == RFTX_IDLE);
  c_tail: cover property (@(posedge i_mclk) state == RFTX_TAIL);
  c_abort: cover property (@(posedge i_mclk) state != RFTX_IDLE && abort_req);
  c_zero_refused: cover property (@(posedge i_mclk) wr_ctrl && bus.wdata[CTRL_SEND_BIT] && frame_length == 8'h00);
  c_page_upper: cover property (@(posedge i_mclk) wr_buf && buffer_page_select);
endmodule

// ---- test/rftx_mod_model.sv ----
/*
  Modulator and amplifier stage model: samples the data line mid-bit while the
  frame is active, counts active cycles and keeps the power code it was given.
  Assumes the bench supplies the bit period in system cycles.
*/
module rftx_mod_model (
  input wire logic i_mclk,
  input wire logic i_active,
  input wire logic i_data,
  input wire logic [4:0] i_power,
  input wire logic signed [31:0] i_bit_cyc,
  output logic [31:0] o_bits,
  output int o_nbits,
  output int o_ncyc,
  output logic [4:0] o_power_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b0;
  initial begin
    o_bits = '0;
    o_nbits = 0;
    o_ncyc = 0;
    o_power_seen = '0;
  end
  // ****************************************
  // Mid-bit sampling of each frame
  // ****************************************
  always @(posedge i_mclk) begin
    prev <= i_active;
    if (i_active) begin
      o_power_seen <= i_power;
      if (!prev) begin
        o_ncyc <= 1;
        o_nbits <= 0;
        o_bits <= '0;
      end else begin
        o_ncyc <= o_ncyc + 1;
        if (o_ncyc % i_bit_cyc == i_bit_cyc / 2) begin
          o_bits <= {o_bits[30:0], i_data};
          o_nbits <= o_nbits + 1;
        end
      end
    end
  end
endmodule

// ---- test/rftx_ctrl_test.sv ----
/*
  Self-checking bench for the RF transmit control block.
  Assumes the 10 MHz clock and a prescale of 20 cycles per code step.
*/
module rftx_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import rftx_pkg::*;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_rfm_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [7:0] i_wdata = '0, o_rdata, d;
  logic o_tx_active, o_tx_data, o_bank_upper;
  logic [4:0] o_power, pw;
  logic [31:0] bits;
  int nbits, ncyc, bit_cyc = PRESCALE_CYC, errors = 0, tests_run = 0;
  always #50 i_mclk = ~i_mclk;
  rftx_ctrl i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_rfm_rst_n(i_rfm_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tx_active(o_tx_active),
    .o_tx_data(o_tx_data), .o_power(o_power), .o_bank_upper(o_bank_upper));
  rftx_mod_model i_mod (.i_mclk(i_mclk), .i_active(o_tx_active), .i_data(o_tx_data), .i_power(o_power),
    .i_bit_cyc(bit_cyc), .o_bits(bits), .o_nbits(nbits), .o_ncyc(ncyc), .o_power_seen(pw));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 20000 && o_tx_active !== 1'b0; k++) @(posedge i_mclk);
    chk("idle", o_tx_active, 1'b0);
  endtask
  // Frame of n bits; expected cycles n times the bit period
  task automatic frame(input logic [7:0] len, input logic [7:0] ctl, input int n, input logic [31:0] exp);
    wr(6'(ADDR_FRAME_LEN), len);
    wr(6'(ADDR_TX_CTRL), ctl);
    rd(6'(ADDR_TX_CTRL), d);
    chk("send_busy", d, ctl);
    wait_idle();
    chk("nbits", nbits, n);
    chk("bits", bits, exp);
    chk("len_ok", (ncyc >= n * bit_cyc - 3) && (ncyc <= n * bit_cyc + 3), 1);
    rd(6'(ADDR_TX_CTRL), d);
    chk("send_clr", d[7], 1'b0);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] exp[4] = '{BIT_RATE_RST, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 4; k++) begin
      rd(6'(k), d);
      chk("reset_reg", d, exp[k]);
    end
    rd(6'h05, d);
    chk("unmapped", d, 8'h00);
    chk("power_rst", o_power, 5'h00);
    $display("reset test done");
  endtask
  task automatic t_page();
    wr(6'(ADDR_TX_CTRL), 8'h00);
    wr(ADDR_BUF_WIN, 8'ha5);
    wr(ADDR_BUF_WIN | 6'h01, 8'h5a);
    wr(6'(ADDR_TX_CTRL), 8'h40);
    #1 chk("bank_up", o_bank_upper, 1'b1);
    wr(ADDR_BUF_WIN, 8'h3c);
    rd(ADDR_BUF_WIN, d);
    chk("upper_byte", d, 8'h3c);
    wr(6'(ADDR_TX_CTRL), 8'h00);
    #1 chk("bank_low", o_bank_upper, 1'b0);
    rd(ADDR_BUF_WIN, d);
    chk("lower_byte", d, 8'ha5);
    $display("page test done");
  endtask
  task automatic t_frames();
    wr(6'(ADDR_BIT_RATE), 8'h00);
    frame(8'h0f, 8'h93, 16, 32'h0000a55a);
    chk("power", pw, 5'h13);
    frame(8'h01, 8'ha0, 4, 32'h0000000b);
    bit_cyc = 2 * PRESCALE_CYC;
    wr(6'(ADDR_BIT_RATE), 8'h01);
    frame(8'h01, 8'h80, 2, 32'h00000002);
    $display("frame test done");
  endtask
  task automatic t_zero_abort();
    wr(6'(ADDR_FRAME_LEN), 8'h00);
    wr(6'(ADDR_TX_CTRL), 8'h80);
    repeat (5) @(posedge i_mclk);
    chk("zero_len", o_tx_active, 1'b0);
    wr(6'(ADDR_FRAME_LEN), 8'hff);
    wr(6'(ADDR_TX_CTRL), 8'h80);
    repeat (100) @(posedge i_mclk);
    rd(6'(ADDR_STATUS), d);
    chk("status_data", d, 8'h01);
    wr(6'(ADDR_TX_CTRL), 8'h00);
    repeat (3) @(posedge i_mclk);
    chk("abort", o_tx_active, 1'b0);
    $display("abort test done");
  endtask
  task automatic t_rfm_reset();
    wr(6'(ADDR_TX_CTRL), 8'h7f);
    @(posedge i_mclk);
    i_rfm_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rfm_rst_n <= 1'b1;
    rd(6'(ADDR_TX_CTRL), d);
    chk("page_kept", d, 8'h40);
    chk("bank_kept", o_bank_upper, 1'b1);
    rd(6'(ADDR_BIT_RATE), d);
    chk("rate_rst", d, BIT_RATE_RST);
    $display("module reset test done");
  endtask
  task automatic t_cpu_reset();
    wr(6'(ADDR_TX_CTRL), 8'h53);
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(6'(ADDR_TX_CTRL), d);
    chk("page_clr", d, 8'h13);
    chk("bank_clr", o_bank_upper, 1'b0);
    chk("power_kept", o_power, 5'h13);
    $display("processor reset test done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    i_rfm_rst_n <= 1'b1;
    t_reset();
    t_page();
    t_frames();
    t_zero_abort();
    t_rfm_reset();
    t_cpu_reset();
    report_and_stop();
  end
  initial begin
    #4000000;
    errors++;
    report_and_stop();
  end
endmodule
